// ---- rtl/bit_shift_flag_unit.sv ----
// bit, shift and flag execution unit of an 8-bit core, one op per command
// assumes an AXI4-Lite master on the same clock; ce freezes every flop except the check copy pf_q
//
// Operation
// - rotate left: carry in bit0, bit7 to carry
// - rotate right: carry in bit7, bit0 out
// - i/o bit set forces bit, flags untouched
// - i/o bit clear zeroes bit, flags untouched
// - bit store copies register bit to transfer
// - bit load writes transfer into register bit
// - overflow set drives overflow flag high
// - overflow clear drives overflow flag low
// - half carry set drives half carry high
// - half carry clear drives half carry low
// - sign set drives signed test flag high
// - sign clear drives signed test flag low
`timescale 1ns/1ps

module bit_shift_flag_unit
  import bsfu_pkg::*;
(
  // clock, reset, enable
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          ce,
  // write address channel
  input  wire logic [ADDR_W-1:0]             awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  // write data channel
  input  wire logic [BUS_W-1:0]              wdata,
  input  wire logic [STRB_W-1:0]             wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  // write response channel
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  // read address channel
  input  wire logic [ADDR_W-1:0]             araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  // read data channel
  output logic [BUS_W-1:0]                   rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  // core state seen by the rest of the chip
  output logic [DATA_W-1:0]                  status_flags,
  output logic [IO_N-1:0][DATA_W-1:0]        io_regs
);

  // ==========================================================================
  // state
  logic                     awready_q, wready_q, bvalid_q;
  logic                     arready_q, rvalid_q;
  logic [1:0]               bresp_q, rresp_q;
  logic [BUS_W-1:0]         rdata_q;
  logic                     aw_full_q, w_full_q;   // held write halves
  logic [ADDR_W-1:0]        waddr_q;               // held write address
  logic [BUS_W-1:0]         wdata_q;               // held write data
  logic [STRB_W-1:0]        wstrb_q;               // held strobes
  logic [DATA_W-1:0]        operand_q;             // general register copy
  logic [DATA_W-1:0]        result_q;              // last datapath result
  logic [DATA_W-1:0]        flags_q;               // status_flags_reg
  logic [IO_N-1:0][DATA_W-1:0] io_q;               // i/o register file

  // ==========================================================================
  // handshakes
  wire aw_hs  = awvalid & awready_q;
  wire w_hs   = wvalid & wready_q;
  wire b_done = bvalid_q & bready;
  wire ar_hs  = arvalid & arready_q;
  wire r_done = rvalid_q & rready;
  // write lands once both halves are held and no response is pending
  wire wr_go  = aw_full_q & w_full_q & ~bvalid_q;

  // ==========================================================================
  // write decode, word index compares
  wire [ADDR_W-1:IO_LO] widx = waddr_q[ADDR_W-1:IO_LO];
  wire hit_w_operand = widx == OFS_OPERAND[ADDR_W-1:IO_LO];
  wire hit_w_cmd     = widx == OFS_CMD[ADDR_W-1:IO_LO];
  wire hit_w_flags   = widx == OFS_FLAGS[ADDR_W-1:IO_LO];
  wire hit_w_io      = waddr_q[ADDR_W-1:IO_HI+1]
                       == OFS_IO_BASE[ADDR_W-1:IO_HI+1];
  wire [1:0] w_io_idx = waddr_q[IO_HI:IO_LO];
  wire lane0         = wstrb_q[0];       // all fields live in byte 0/1
  // result is read-only, so a write there is refused like a hole
  wire wr_mapped = hit_w_operand | hit_w_cmd | hit_w_flags | hit_w_io;
  wire [1:0] wr_resp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
  wire wr_now        = wr_go & ce & lane0;
  wire exec          = wr_now & hit_w_cmd;   // command fires this edge

  // ==========================================================================
  // read decode
  wire [ADDR_W-1:IO_LO] ridx = araddr[ADDR_W-1:IO_LO];
  wire hit_r_operand = ridx == OFS_OPERAND[ADDR_W-1:IO_LO];
  wire hit_r_result  = ridx == OFS_RESULT[ADDR_W-1:IO_LO];
  wire hit_r_flags   = ridx == OFS_FLAGS[ADDR_W-1:IO_LO];
  wire hit_r_cmd     = ridx == OFS_CMD[ADDR_W-1:IO_LO];
  wire hit_r_io      = araddr[ADDR_W-1:IO_HI+1]
                       == OFS_IO_BASE[ADDR_W-1:IO_HI+1];
  wire [1:0] r_io_idx = araddr[IO_HI:IO_LO];
  // command is write-only and reads as zero with okay
  wire rd_mapped = hit_r_operand | hit_r_result | hit_r_flags
                   | hit_r_cmd | hit_r_io;
  wire [DATA_W-1:0] rd_byte =
      hit_r_operand ? operand_q :
      hit_r_result  ? result_q  :
      hit_r_flags   ? flags_q   :
      hit_r_io      ? io_q[r_io_idx] : RST_BYTE;
  wire [BUS_W-1:0] rd_word = {{(BUS_W-DATA_W){1'b0}}, rd_byte};

  // ==========================================================================
  // datapath
  wire cmd_t cmd = cmd_t'(wdata_q[CMD_W-1:0]);
  logic [DATA_W-1:0] res_d;    // result candidate
  logic [DATA_W-1:0] flg_d;    // flag candidate
  logic              cout;     // bit shifted out
  logic              is_shift; // shift family updates arithmetic flags
  logic              has_res;  // op writes the result register
  // one combinational pass; every op is single cycle
  always_comb begin
    res_d    = result_q;
    flg_d    = flags_q;
    cout     = 1'b0;
    is_shift = cmd.op inside {OP_SHL, OP_SHR, OP_RCL, OP_RCR, OP_SRA};
    has_res  = is_shift | (cmd.op == OP_SWAP) | (cmd.op == OP_TGET);
    unique case (cmd.op)
      OP_SHL: begin
        res_d    = {operand_q[MSB-1:0], 1'b0};
        cout     = operand_q[MSB];
        flg_d[FLAG_H] = operand_q[NIB-1];
      end
      OP_SHR: begin
        res_d    = {1'b0, operand_q[MSB:1]};
        cout     = operand_q[0];
      end
      OP_RCL: begin
        res_d    = {operand_q[MSB-1:0], flags_q[FLAG_C]};
        cout     = operand_q[MSB];
        flg_d[FLAG_H] = operand_q[NIB-1];
      end
      OP_RCR: begin
        res_d    = {flags_q[FLAG_C], operand_q[MSB:1]};
        cout     = operand_q[0];
      end
      OP_SRA: begin
        res_d    = {operand_q[MSB], operand_q[MSB:1]};
        cout     = operand_q[0];
      end
      // flags left alone on purpose
      OP_SWAP: res_d = {operand_q[NIB-1:0], operand_q[MSB:NIB]};
      // dedicated set/clear ops are this op with a fixed index
      OP_FSET: flg_d[cmd.bit_sel] = 1'b1;
      OP_FCLR: flg_d[cmd.bit_sel] = 1'b0;
      OP_TPUT: flg_d[FLAG_T] = operand_q[cmd.bit_sel];
      OP_TGET: begin
        res_d = operand_q;
        res_d[cmd.bit_sel] = flags_q[FLAG_T];
      end
      // i/o ops touch only the i/o file below
      OP_IOSET, OP_IOCLR, OP_NONE: ;
      default: ;   // spare codes do nothing
    endcase
    // shift family: zero, carry, negative, overflow = n xor c
    if (is_shift) begin
      flg_d[FLAG_C] = cout;
      flg_d[FLAG_Z] = res_d == RST_BYTE;
      flg_d[FLAG_N] = res_d[MSB];
      flg_d[FLAG_V] = res_d[MSB] ^ cout;
    end
  end
  // ==========================================================================
  // write channel: each half held until the response is taken
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      waddr_q   <= OFS_OPERAND;
      wdata_q   <= RST_WORD;
      wstrb_q   <= '0;
    end else if (ce) begin
      // address and data taken in either order
      if (aw_hs) begin
        aw_full_q <= 1'b1;
        awready_q <= 1'b0;
        waddr_q   <= awaddr;
      end
      if (w_hs) begin
        w_full_q <= 1'b1;
        wready_q <= 1'b0;
        wdata_q  <= wdata;
        wstrb_q  <= wstrb;
      end
      // response follows both halves
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_resp;
      end
      // reopen only after the master takes the response
      if (b_done) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // read channel: data one cycle after the address is taken
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rdata_q   <= RST_WORD;
      rresp_q   <= RESP_OKAY;
    end else if (ce) begin
      if (ar_hs) begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= rd_word;
        rresp_q   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (r_done) begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // operand, result and flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      operand_q <= RST_BYTE;
      result_q  <= RST_BYTE;
      flags_q   <= RST_BYTE;
    end else begin
      if (wr_now && hit_w_operand) operand_q <= wdata_q[DATA_W-1:0];
      // software write and command never share a cycle
      if (wr_now && hit_w_flags) begin
        flags_q <= wdata_q[DATA_W-1:0];
      end else if (exec) begin
        flags_q <= flg_d;
      end
      if (exec && has_res) result_q <= res_d;
    end
  end

  // ==========================================================================
  // i/o register file, one entry per generate pass
  for (genvar gi = 0; gi < IO_N; gi++) begin : g_io
    wire sel_cmd = exec && cmd.io_addr == 2'(gi);
    wire sel_sw  = wr_now && hit_w_io && w_io_idx == 2'(gi);
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        io_q[gi] <= RST_BYTE;
      end else if (sel_sw) begin
        io_q[gi] <= wdata_q[DATA_W-1:0];
      end else if (sel_cmd && cmd.op == OP_IOSET) begin
        io_q[gi][cmd.bit_sel] <= 1'b1;
      end else if (sel_cmd && cmd.op == OP_IOCLR) begin
        io_q[gi][cmd.bit_sel] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // outputs straight from flops
  assign awready      = awready_q;
  assign wready       = wready_q;
  assign bvalid       = bvalid_q;
  assign bresp        = bresp_q;
  assign arready      = arready_q;
  assign rvalid       = rvalid_q;
  assign rdata        = rdata_q;
  assign rresp        = rresp_q;
  assign status_flags = flags_q;
  assign io_regs      = io_q;
  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // flags one cycle back, only the checks read these
  logic [DATA_W-1:0] pf_q;
  always_ff @(posedge clk) pf_q <= flags_q;
  wire [BIT_W-1:0] xb = cmd.bit_sel;
  property p_rlc;
    exec && cmd.op == OP_RCL |=> result_q == {operand_q[MSB-1:0],
      pf_q[FLAG_C]} && flags_q[FLAG_C] == operand_q[MSB];
  endproperty
  a_rlc: assert property (p_rlc) else $error("rotate left wrong");
  property p_rrc;
    exec && cmd.op == OP_RCR |=> result_q == {pf_q[FLAG_C],
      operand_q[MSB:1]} && flags_q[FLAG_C] == operand_q[0]
      && flags_q[FLAG_N] == pf_q[FLAG_C];
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate right wrong");
  property p_ioset;
    logic [1:0] a; logic [BIT_W-1:0] b;
    (exec && cmd.op == OP_IOSET, a = cmd.io_addr, b = xb)
      |=> io_q[a][b] && $stable(flags_q);
  endproperty
  a_ioset: assert property (p_ioset) else $error("io set wrong");
  property p_ioclr;
    logic [1:0] a; logic [BIT_W-1:0] b;
    (exec && cmd.op == OP_IOCLR, a = cmd.io_addr, b = xb)
      |=> !io_q[a][b] && $stable(flags_q);
  endproperty
  a_ioclr: assert property (p_ioclr) else $error("io clear wrong");
  property p_tput;
    logic [BIT_W-1:0] b;
    (exec && cmd.op == OP_TPUT, b = xb) |=> flags_q[FLAG_T] ==
      operand_q[b] && (flags_q & 8'hbf) == (pf_q & 8'hbf);
  endproperty
  a_tput: assert property (p_tput) else $error("bit store wrong");
  property p_tget;
    logic [BIT_W-1:0] b;
    (exec && cmd.op == OP_TGET, b = xb) |=> result_q[b] == pf_q[FLAG_T]
      && $stable(flags_q);
  endproperty
  a_tget: assert property (p_tget) else $error("bit load wrong");
  // v set and clear compare the whole flag byte, so a stray side effect also fails
  property p_vset;
    exec && cmd.op == OP_FSET && xb == FLAG_V
      |=> flags_q == (pf_q | (8'h01 << FLAG_V));
  endproperty
  a_vset: assert property (p_vset) else $error("v set wrong");
  property p_vclr;
    exec && cmd.op == OP_FCLR && xb == FLAG_V
      |=> flags_q == (pf_q & ~(8'h01 << FLAG_V));
  endproperty
  a_vclr: assert property (p_vclr) else $error("v clear wrong");
  property p_hflag;
    exec && (cmd.op == OP_FSET || cmd.op == OP_FCLR) && xb == FLAG_H
      |=> flags_q[FLAG_H] == !$past(cmd.op == OP_FCLR);
  endproperty
  a_hflag: assert property (p_hflag) else $error("h flag wrong");
  property p_sflag;
    exec && (cmd.op == OP_FSET || cmd.op == OP_FCLR) && xb == FLAG_S
      |=> flags_q[FLAG_S] == !$past(cmd.op == OP_FCLR);
  endproperty
  a_sflag: assert property (p_sflag) else $error("s flag wrong");
  property p_shift;
    exec && cmd.op == OP_SRA |=> result_q[MSB] == operand_q[MSB]
      && result_q[MSB-1:0] == operand_q[MSB:1];
  endproperty
  a_shift: assert property (p_shift) else $error("sign shift wrong");
  property p_swap;
    exec && cmd.op == OP_SWAP |=> result_q == {operand_q[NIB-1:0],
      operand_q[MSB:NIB]} && $stable(flags_q);
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrong");
  property p_fgen;
    logic [BIT_W-1:0] b;
    (exec && cmd.op == OP_FSET, b = xb) |=> flags_q[b]
      && (flags_q | (8'h01 << b)) == (pf_q | (8'h01 << b));
  endproperty
  a_fgen: assert property (p_fgen) else $error("flag set wrong");
endmodule : bit_shift_flag_unit

// ---- rtl/bsfu_pkg.sv ----
// constants, field layouts and carrier types for the bit, shift and flag unit
// assumes one 40 MHz core clock and an AXI4-Lite register port of 32 bits
package bsfu_pkg;

  // ==========================================================================
  // widths
  localparam int unsigned DATA_W = 8;    // operand and flag width
  localparam int unsigned ADDR_W = 8;    // register bus byte address width
  localparam int unsigned BUS_W  = 32;   // register bus data width
  localparam int unsigned STRB_W = 4;    // byte lanes on the bus
  localparam int unsigned IO_N   = 4;    // entries in the i/o register file
  localparam int unsigned BIT_W  = 3;    // bit select width
  localparam int unsigned CMD_W  = 10;   // used bits of the command word

  // ==========================================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_OPERAND = 8'h00; // operand, rw
  localparam logic [ADDR_W-1:0] OFS_CMD     = 8'h04; // command, wo
  localparam logic [ADDR_W-1:0] OFS_RESULT  = 8'h08; // result, ro
  localparam logic [ADDR_W-1:0] OFS_FLAGS   = 8'h0c; // status_flags_reg, rw
  localparam logic [ADDR_W-1:0] OFS_IO_BASE = 8'h10; // i/o file, 4 words
  localparam int unsigned IO_HI  = 3;    // top bit of the i/o word index
  localparam int unsigned IO_LO  = 2;    // low bit of any word index

  // ==========================================================================
  // reset values
  localparam logic [DATA_W-1:0] RST_BYTE  = 8'h00;
  localparam logic [BUS_W-1:0]  RST_WORD  = 32'h0000_0000;

  // ==========================================================================
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // flag positions inside status_flags_reg
  localparam logic [BIT_W-1:0] FLAG_C = 3'h0; // carry
  localparam logic [BIT_W-1:0] FLAG_Z = 3'h1; // zero
  localparam logic [BIT_W-1:0] FLAG_N = 3'h2; // negative
  localparam logic [BIT_W-1:0] FLAG_V = 3'h3; // two's complement overflow
  localparam logic [BIT_W-1:0] FLAG_S = 3'h4; // signed test
  localparam logic [BIT_W-1:0] FLAG_H = 3'h5; // half carry
  localparam logic [BIT_W-1:0] FLAG_T = 3'h6; // transfer
  localparam logic [BIT_W-1:0] FLAG_I = 3'h7; // global interrupt enable
  localparam int unsigned       MSB    = 7;    // operand sign bit
  localparam int unsigned       NIB    = 4;    // nibble width

  // ==========================================================================
  // operations carried by the command word
  typedef enum logic [3:0] {
    OP_NONE  = 4'h0,
    OP_SHL   = 4'h1,  // shift_left_logical
    OP_SHR   = 4'h2,  // shift_right_logical
    OP_RCL   = 4'h3,  // rotate_left_carry
    OP_RCR   = 4'h4,  // rotate_right_carry
    OP_SRA   = 4'h5,  // shift_right_arith
    OP_SWAP  = 4'h6,  // nibble swap
    OP_FSET  = 4'h7,  // flag_set_generic
    OP_FCLR  = 4'h8,  // flag_clear_generic
    OP_IOSET = 4'h9,  // io_bit_set
    OP_IOCLR = 4'ha,  // io_bit_clear
    OP_TPUT  = 4'hb,  // bit_to_transfer_flag
    OP_TGET  = 4'hc   // transfer_flag_to_bit
  } op_t;

  // command word, low bits of the bus word
  typedef struct packed {
    logic [1:0]       io_addr;  // bits 9:8, i/o entry
    logic             spare;    // bit 7, ignored
    logic [BIT_W-1:0] bit_sel;  // bits 6:4, bit or flag index
    op_t              op;       // bits 3:0
  } cmd_t;

endpackage : bsfu_pkg

// ---- verif/bit_shift_flag_unit_test.sv ----
// self-checking bench for the bit, shift and flag unit
// assumes the model below drives the bus; clock enable held high
`timescale 1ns/1ps

module bit_shift_flag_unit_test
  import bsfu_pkg::*;
;
  logic clk, rstn, ce, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [BUS_W-1:0]  wdata, rdata, v;
  logic [STRB_W-1:0] wstrb;
  logic [1:0]        bresp, rresp, rsp;
  logic [DATA_W-1:0] status_flags;
  logic [IO_N-1:0][DATA_W-1:0] io_regs;
  int n_errors, samples_checked;
  // shift table: op, operand, carry in, result, flags after
  op_t sh_op[8] = '{OP_SHL, OP_SHR, OP_RCL, OP_RCR, OP_RCR, OP_SRA,
                    OP_SHR, OP_SHL};
  logic [7:0] sh_a[8] = '{8'h81, 8'h81, 8'h81, 8'h81, 8'h81, 8'h81,
                          8'h01, 8'h08};
  logic sh_c[8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [7:0] sh_r[8] = '{8'h02, 8'h40, 8'h03, 8'h40, 8'hc0, 8'hc0,
                          8'h00, 8'h10};
  logic [7:0] sh_f[8] = '{8'h19, 8'h19, 8'h19, 8'h19, 8'h15, 8'h15,
                          8'h1b, 8'h30};

  bit_shift_flag_unit DUT (.clk(clk), .rstn(rstn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .status_flags(status_flags), .io_regs(io_regs));
  core_master_model model (.clk(clk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ==========================================================================
  // helpers
  task automatic check(input logic [BUS_W-1:0] seen,
                       input logic [BUS_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    model.wr(a, {24'h0, d}, rsp);
  endtask : wreg

  // command word: entry, spare, bit index, op
  task automatic run(input op_t o, input logic [2:0] b, input logic [1:0] k);
    model.wr(OFS_CMD, {22'h0, k, 1'b0, b, o}, rsp);
  endtask : run

  task automatic tally_and_finish;
    $display("mismatches %0d of %0d checks", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================================================
  // clock, watchdog far beyond the 112 transfers below
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end

  // ==========================================================================
  // tests
  initial begin
    rstn = 1'b0;
    ce   = 1'b1;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check(status_flags, 32'h0);
    check(io_regs, 32'h0);
    // shifts and rotates, S preset to see it kept
    for (int i = 0; i < 8; i++) begin
      wreg(OFS_OPERAND, sh_a[i]);
      wreg(OFS_FLAGS, {7'h08, sh_c[i]});
      run(sh_op[i], 3'h0, 2'h0);
      model.rd(OFS_RESULT, v, rsp);
      check(v, {24'h0, sh_r[i]});
      check(status_flags, sh_f[i]);
    end
    // nibble swap leaves flags alone
    wreg(OFS_OPERAND, 8'h3c);
    wreg(OFS_FLAGS, 8'ha5);
    run(OP_SWAP, 3'h0, 2'h0);
    model.rd(OFS_RESULT, v, rsp);
    check(v, 32'hc3);
    check(status_flags, 8'ha5);
    // every flag index set from all-clear and cleared from all-set
    for (int i = 0; i < 8; i++) begin
      wreg(OFS_FLAGS, 8'h00);
      run(OP_FSET, 3'(i), 2'h0);
      check(status_flags, 8'h01 << i);
      wreg(OFS_FLAGS, 8'hff);
      run(OP_FCLR, 3'(i), 2'h0);
      model.rd(OFS_FLAGS, v, rsp);
      check(v, {24'h0, ~(8'h01 << i)});
    end
    // i/o bits in each entry, flags must not move
    for (int k = 0; k < 4; k++) begin
      wreg(OFS_FLAGS, 8'ha5);
      wreg(OFS_IO_BASE + 8'(4 * k), 8'h00);
      run(OP_IOSET, 3'(2 * k + 1), 2'(k));
      check(io_regs[k], 8'h01 << (2 * k + 1));
      wreg(OFS_IO_BASE + 8'(4 * k), 8'hff);
      run(OP_IOCLR, 3'(2 * k), 2'(k));
      check(io_regs[k], {24'h0, ~(8'h01 << (2 * k))});
      check(status_flags, 8'ha5);
    end
    // bit store into transfer flag, one and zero
    wreg(OFS_OPERAND, 8'h20);
    wreg(OFS_FLAGS, 8'hbf);
    run(OP_TPUT, 3'h5, 2'h0);
    check(status_flags, 8'hff);
    run(OP_TPUT, 3'h4, 2'h0);
    check(status_flags, 8'hbf);
    // bit load from transfer flag into the result
    wreg(OFS_FLAGS, 8'h40);
    wreg(OFS_OPERAND, 8'h00);
    run(OP_TGET, 3'h3, 2'h0);
    model.rd(OFS_RESULT, v, rsp);
    check(v, 32'h08);
    check(status_flags, 8'h40);
    wreg(OFS_FLAGS, 8'h00);
    wreg(OFS_OPERAND, 8'hff);
    run(OP_TGET, 3'h7, 2'h0);
    model.rd(OFS_RESULT, v, rsp);
    check(v, 32'h7f);
    // responses: read-only result and unmapped places refused, command read okay
    model.wr(OFS_RESULT, 32'h55, rsp);
    check(rsp, RESP_SLVERR);
    model.wr(8'h20, 32'h55, rsp);
    check(rsp, RESP_SLVERR);
    model.rd(8'h24, v, rsp);
    check({v, rsp}, {32'h0, RESP_SLVERR});
    model.rd(OFS_CMD, v, rsp);
    check({v, rsp}, {32'h0, RESP_OKAY});
    tally_and_finish();
  end
endmodule : bit_shift_flag_unit_test

// ---- verif/core_master_model.sv ----
// far side model: the core decoder issuing register bus transfers
// assumes one clock shared with the unit; bready and rready stay high
`timescale 1ns/1ps

module core_master_model
  import bsfu_pkg::*;
(
  // clock
  input  wire logic              clk,
  // write channels
  output logic [ADDR_W-1:0]      awaddr,
  output logic                   awvalid,
  input  wire logic              awready,
  output logic [BUS_W-1:0]       wdata,
  output logic [STRB_W-1:0]      wstrb,
  output logic                   wvalid,
  input  wire logic              wready,
  input  wire logic [1:0]        bresp,
  input  wire logic              bvalid,
  output logic                   bready,
  // read channels
  output logic [ADDR_W-1:0]      araddr,
  output logic                   arvalid,
  input  wire logic              arready,
  input  wire logic [BUS_W-1:0]  rdata,
  input  wire logic [1:0]        rresp,
  input  wire logic              rvalid,
  output logic                   rready
);
  // ==========================================================================
  // idle values; released payload is inverted so stale data never matches
  initial begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, arvalid} = 3'b000;
    bready = 1'b1;
    rready = 1'b1;
  end

  // one write; both channels offered together, each released when taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d,
                    output logic [1:0] r);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end while (!bvalid);
    r = bresp;
  endtask : wr

  // one read; data taken at the edge where rvalid is seen
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [BUS_W-1:0] d,
                    output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : rd
endmodule : core_master_model
